// file: hdl/cdrov_defs.svh
// Register offsets, reset values and field positions of the CDR override control registers.
`ifndef CDROV_DEFS_SVH
`define CDROV_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CDROV_ADDR_RSVD 8'h08
`define CDROV_ADDR_ENA 8'h09
`define CDROV_ADDR_ENB 8'h0a

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CDROV_RST_RSVD 8'h60
`define CDROV_RST_ENA 8'h00
`define CDROV_RST_ENB 8'h50

// ----------------------------------------------------------------------------
// Fields of loop_override_enables_a
// ----------------------------------------------------------------------------
`define CDROV_A_VCO_CAP 7
`define CDROV_A_LPF_LVL 6
`define CDROV_A_BYPASS 5
`define CDROV_A_DET_VCO 4
`define CDROV_A_CP_PD 3
`define CDROV_A_DIVSEL 2
`define CDROV_A_FLD 1
`define CDROV_A_LOCK_FD 0

// ----------------------------------------------------------------------------
// Fields of loop_override_enables_b
// ----------------------------------------------------------------------------
`define CDROV_B_SBT 7
`define CDROV_B_IDAC 6
`define CDROV_B_TRIP 5
`define CDROV_B_RANGE 4
`define CDROV_B_RST_OV 3
`define CDROV_B_RST_VAL 2
`define CDROV_B_LOCK_OV 1
`define CDROV_B_LOCK_VAL 0

`endif

// file: hdl/cdrov_pkg.sv
// Types shared by the CDR override control register block.
package cdrov_pkg;

    // ------------------------------------------------------------------------
    // Loop control bundle
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] vco_cap_count;
        logic [4:0] loop_filter_dac;
        logic [2:0] loopthrough_sel;
        logic frequency_detector_enable;
        logic phase_detector_powerdown;
        logic vco_powerdown;
        logic quadrature_detector_powerdown;
        logic freq_charge_pump_powerdown;
        logic phase_charge_pump_powerdown;
        logic [2:0] divider_select;
        logic fast_lock_detector_powerdown;
        logic single_bit_transition_en;
        logic [2:0] phase_pump_current;
        logic [2:0] freq_pump_current;
        logic [7:0] filter_trip_level;
        logic filter_range_enable;
        logic recovery_reset;
        logic recovery_lock;
    } cdrov_loop_ctl_t;

    // ------------------------------------------------------------------------
    // Register access port
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cdrov_reg_req_t;

    typedef struct packed {
        logic rvalid;
        logic [7:0] rdata;
    } cdrov_reg_rsp_t;

endpackage

// file: hdl/cdrov_regs.sv
// Per-channel CDR override enable registers and the loop control selection they steer.
`include "cdrov_defs.svh"

// ----------------------------------------------------------------------------
// Overview
// ----------------------------------------------------------------------------
// Overview of operation
// RL1: With the capacitor-count override set, the VCO capacitor count comes from the override.
// RL2: With the loop-filter level override set, the loop-filter DAC value comes from the override.
// RL3: With the detector-bypass override set, the loopthrough selections come from the override.
// RL4: With the detector and VCO override set, the four detector and VCO controls come from it.
// RL5: With the charge-pump power-down override set, both pump power-downs come from it.
// RL6: With the divider override set the divider select comes from it, else automatic.
// RL7: With the fast-lock override set, the fast-lock detector power-down comes from it.
// RL8: With lock-state mode set, the frequency detector stays enabled while the loop is locked; a set detector and VCO override takes precedence here.
// RL9: With the single-bit-transition override set, that enable comes from the override.
// RL10: With the pump current override set (its reset state), both pump currents come from it.
// RL11: With the trip override set, the eight-bit comparator trip levels come from the override.
// RL12: With the range override set (its reset state), the filter range enable comes from it.
// RL13: With the reset override set, the loop reset follows the software reset bit.
// RL14: A software reset bit of one holds the loop in reset and zero lets it run.
// RL15: With the lock override set, the lock indication shows the software lock bit.
// RL16: With an override clear, the control follows the internal state machine, except the frequency detector enable held on by lock-state mode (RL8).
// RL17: Software enables channel access and selects the channel before touching these registers.

module cdrov_regs
    import cdrov_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic channel_bus_access_en,
    input wire logic channel_selected,
    input wire cdrov_reg_req_t reg_req,
    output cdrov_reg_rsp_t reg_rsp,
    input wire cdrov_loop_ctl_t sm_ctl,
    input wire cdrov_loop_ctl_t ov_val,
    input wire logic sm_locked_state,
    output cdrov_loop_ctl_t loop_ctl
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    logic [7:0] rsvd_reg;
    logic [7:0] ena_reg;
    logic [7:0] enb_reg;
    logic access_ok;
    logic wr_rsvd;
    logic wr_ena;
    logic wr_enb;

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction

    // Accesses only count when the channel is reachable from the bus.
    assign access_ok = channel_bus_access_en & channel_selected; // see RL17
    assign wr_rsvd = reg_req.wr & access_ok & addr_hit(reg_req.addr, `CDROV_ADDR_RSVD);
    assign wr_ena = reg_req.wr & access_ok & addr_hit(reg_req.addr, `CDROV_ADDR_ENA);
    assign wr_enb = reg_req.wr & access_ok & addr_hit(reg_req.addr, `CDROV_ADDR_ENB);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rsvd_reg <= `CDROV_RST_RSVD;
        end
        else if (wr_rsvd)
        begin
            rsvd_reg <= reg_req.wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ena_reg <= `CDROV_RST_ENA;
        end
        else if (wr_ena)
        begin
            ena_reg <= reg_req.wdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            enb_reg <= `CDROV_RST_ENB; // see RL10 see RL12
        end
        else if (wr_enb)
        begin
            enb_reg <= reg_req.wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    logic [7:0] rdata_next;

    always_comb
    begin
        rdata_next = 8'h00;
        if (addr_hit(reg_req.addr, `CDROV_ADDR_RSVD))
        begin
            rdata_next = rsvd_reg;
        end
        else if (addr_hit(reg_req.addr, `CDROV_ADDR_ENA))
        begin
            rdata_next = ena_reg;
        end
        else if (addr_hit(reg_req.addr, `CDROV_ADDR_ENB))
        begin
            rdata_next = enb_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            reg_rsp <= '0;
        end
        else
        begin
            reg_rsp.rvalid <= reg_req.rd & access_ok; // see RL17
            reg_rsp.rdata <= (reg_req.rd & access_ok) ? rdata_next : 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Loop control selection
    // ------------------------------------------------------------------------
    cdrov_loop_ctl_t loop_ctl_next;

    always_comb
    begin
        // Every field starts from the state machine and is replaced where enabled.
        loop_ctl_next = sm_ctl; // see RL16
        if (ena_reg[`CDROV_A_VCO_CAP])
        begin
            loop_ctl_next.vco_cap_count = ov_val.vco_cap_count; // see RL1
        end
        if (ena_reg[`CDROV_A_LPF_LVL])
        begin
            loop_ctl_next.loop_filter_dac = ov_val.loop_filter_dac; // see RL2
        end
        if (ena_reg[`CDROV_A_BYPASS])
        begin
            loop_ctl_next.loopthrough_sel = ov_val.loopthrough_sel; // see RL3
        end
        if (ena_reg[`CDROV_A_LOCK_FD] && sm_locked_state)
        begin
            loop_ctl_next.frequency_detector_enable = 1'b1; // see RL8
        end
        if (ena_reg[`CDROV_A_DET_VCO])
        begin
            // A direct override beats the lock-state mode.
            loop_ctl_next.frequency_detector_enable = ov_val.frequency_detector_enable; // see RL4
            loop_ctl_next.phase_detector_powerdown = ov_val.phase_detector_powerdown;
            loop_ctl_next.vco_powerdown = ov_val.vco_powerdown;
            loop_ctl_next.quadrature_detector_powerdown = ov_val.quadrature_detector_powerdown;
        end
        if (ena_reg[`CDROV_A_CP_PD])
        begin
            loop_ctl_next.freq_charge_pump_powerdown = ov_val.freq_charge_pump_powerdown; // see RL5
            loop_ctl_next.phase_charge_pump_powerdown = ov_val.phase_charge_pump_powerdown;
        end
        if (ena_reg[`CDROV_A_DIVSEL])
        begin
            loop_ctl_next.divider_select = ov_val.divider_select; // see RL6
        end
        if (ena_reg[`CDROV_A_FLD])
        begin
            loop_ctl_next.fast_lock_detector_powerdown = ov_val.fast_lock_detector_powerdown; // see RL7
        end
        if (enb_reg[`CDROV_B_SBT])
        begin
            loop_ctl_next.single_bit_transition_en = ov_val.single_bit_transition_en; // see RL9
        end
        if (enb_reg[`CDROV_B_IDAC])
        begin
            loop_ctl_next.phase_pump_current = ov_val.phase_pump_current; // see RL10
            loop_ctl_next.freq_pump_current = ov_val.freq_pump_current;
        end
        if (enb_reg[`CDROV_B_TRIP])
        begin
            loop_ctl_next.filter_trip_level = ov_val.filter_trip_level; // see RL11
        end
        if (enb_reg[`CDROV_B_RANGE])
        begin
            loop_ctl_next.filter_range_enable = ov_val.filter_range_enable; // see RL12
        end
        if (enb_reg[`CDROV_B_RST_OV])
        begin
            loop_ctl_next.recovery_reset = enb_reg[`CDROV_B_RST_VAL]; // see RL13 see RL14
        end
        if (enb_reg[`CDROV_B_LOCK_OV])
        begin
            loop_ctl_next.recovery_lock = enb_reg[`CDROV_B_LOCK_VAL]; // see RL15
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            loop_ctl <= '0;
        end
        else
        begin
            loop_ctl <= loop_ctl_next;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    cap_override_a: assert property (ena_reg[`CDROV_A_VCO_CAP] // see RL1
        |=> loop_ctl.vco_cap_count == $past(ov_val.vco_cap_count))
        else $error("capacitor count not taken from override");

    cap_follow_a: assert property (!ena_reg[`CDROV_A_VCO_CAP] // see RL16
        |=> loop_ctl.vco_cap_count == $past(sm_ctl.vco_cap_count))
        else $error("capacitor count not from state machine");

    lpf_override_a: assert property (ena_reg[`CDROV_A_LPF_LVL] // see RL2
        |=> loop_ctl.loop_filter_dac == $past(ov_val.loop_filter_dac))
        else $error("loop filter level not taken from override");

    bypass_override_a: assert property (ena_reg[`CDROV_A_BYPASS] // see RL3
        |=> loop_ctl.loopthrough_sel == $past(ov_val.loopthrough_sel))
        else $error("loopthrough select not taken from override");

    vco_pd_override_a: assert property (ena_reg[`CDROV_A_DET_VCO] // see RL4
        |=> loop_ctl.vco_powerdown == $past(ov_val.vco_powerdown))
        else $error("vco powerdown not taken from override");

    det_override_a: assert property (ena_reg[`CDROV_A_DET_VCO] // see RL4
        |=> loop_ctl.frequency_detector_enable == $past(ov_val.frequency_detector_enable)
        && loop_ctl.phase_detector_powerdown == $past(ov_val.phase_detector_powerdown)
        && loop_ctl.quadrature_detector_powerdown
        == $past(ov_val.quadrature_detector_powerdown))
        else $error("detector controls not taken from override");

    pump_pd_override_a: assert property (ena_reg[`CDROV_A_CP_PD] // see RL5
        |=> loop_ctl.freq_charge_pump_powerdown == $past(ov_val.freq_charge_pump_powerdown)
        && loop_ctl.phase_charge_pump_powerdown == $past(ov_val.phase_charge_pump_powerdown))
        else $error("pump powerdowns not taken from override");

    divsel_override_a: assert property (ena_reg[`CDROV_A_DIVSEL] // see RL6
        |=> loop_ctl.divider_select == $past(ov_val.divider_select))
        else $error("divider select not taken from override");

    divsel_auto_a: assert property (!ena_reg[`CDROV_A_DIVSEL] // see RL6
        |=> loop_ctl.divider_select == $past(sm_ctl.divider_select))
        else $error("divider select not automatic while override clear");

    fld_override_a: assert property (ena_reg[`CDROV_A_FLD] // see RL7
        |=> loop_ctl.fast_lock_detector_powerdown == $past(ov_val.fast_lock_detector_powerdown))
        else $error("fast lock powerdown not taken from override");

    lock_fd_on_a: assert property (ena_reg[`CDROV_A_LOCK_FD] && sm_locked_state // see RL8
        && !ena_reg[`CDROV_A_DET_VCO] |=> loop_ctl.frequency_detector_enable)
        else $error("frequency detector off in lock state");

    fd_follow_a: assert property (!ena_reg[`CDROV_A_DET_VCO] // see RL16
        && !(ena_reg[`CDROV_A_LOCK_FD] && sm_locked_state)
        |=> loop_ctl.frequency_detector_enable == $past(sm_ctl.frequency_detector_enable))
        else $error("frequency detector enable not from state machine");

    sbt_override_a: assert property (enb_reg[`CDROV_B_SBT] // see RL9
        |=> loop_ctl.single_bit_transition_en == $past(ov_val.single_bit_transition_en))
        else $error("transition enable not taken from override");

    pump_current_a: assert property (enb_reg[`CDROV_B_IDAC] // see RL10
        |=> loop_ctl.phase_pump_current == $past(ov_val.phase_pump_current)
        && loop_ctl.freq_pump_current == $past(ov_val.freq_pump_current))
        else $error("pump currents not taken from override");

    pump_follow_a: assert property (!enb_reg[`CDROV_B_IDAC] // see RL16
        |=> loop_ctl.phase_pump_current == $past(sm_ctl.phase_pump_current))
        else $error("pump current not from state machine");

    trip_override_a: assert property (enb_reg[`CDROV_B_TRIP] // see RL11
        |=> loop_ctl.filter_trip_level == $past(ov_val.filter_trip_level))
        else $error("trip levels not taken from override");

    range_override_a: assert property (enb_reg[`CDROV_B_RANGE] // see RL12
        |=> loop_ctl.filter_range_enable == $past(ov_val.filter_range_enable))
        else $error("filter range not taken from override");

    sw_reset_a: assert property (wr_enb && reg_req.wdata[`CDROV_B_RST_OV] // see RL13
        && reg_req.wdata[`CDROV_B_RST_VAL] ##1 !wr_enb |=> loop_ctl.recovery_reset)
        else $error("software reset does not hold the loop");

    sw_run_a: assert property (enb_reg[`CDROV_B_RST_OV] && !enb_reg[`CDROV_B_RST_VAL] // see RL14
        |=> !loop_ctl.recovery_reset)
        else $error("loop held in reset with reset bit clear");

    reset_follow_a: assert property (!enb_reg[`CDROV_B_RST_OV] // see RL16
        |=> loop_ctl.recovery_reset == $past(sm_ctl.recovery_reset))
        else $error("loop reset not from state machine");

    lock_ind_a: assert property (enb_reg[`CDROV_B_LOCK_OV] // see RL15
        |=> loop_ctl.recovery_lock == $past(enb_reg[`CDROV_B_LOCK_VAL]))
        else $error("lock indication ignores override bit");

    lock_follow_a: assert property (!enb_reg[`CDROV_B_LOCK_OV] // see RL16
        |=> loop_ctl.recovery_lock == $past(sm_ctl.recovery_lock))
        else $error("lock indication not from detector");

    reset_values_a: assert property (!$past(rst_n) // see RL10
        |-> ena_reg == `CDROV_RST_ENA && enb_reg == `CDROV_RST_ENB && rsvd_reg == `CDROV_RST_RSVD)
        else $error("registers not at reset values after reset");

    gated_write_a: assert property (reg_req.wr && !access_ok // see RL17
        |=> $stable(ena_reg) && $stable(enb_reg) && $stable(rsvd_reg))
        else $error("write accepted without channel access");

    no_read_idle_a: assert property (!(reg_req.rd && access_ok) // see RL17
        |=> !reg_rsp.rvalid && reg_rsp.rdata == 8'h00)
        else $error("read answer without an accepted read");

    unmapped_read_a: assert property (reg_req.rd && access_ok // see RL17
        && !addr_hit(reg_req.addr, `CDROV_ADDR_RSVD)
        && !addr_hit(reg_req.addr, `CDROV_ADDR_ENA)
        && !addr_hit(reg_req.addr, `CDROV_ADDR_ENB)
        |=> reg_rsp.rvalid && reg_rsp.rdata == 8'h00)
        else $error("unmapped read not answered with zero");

    read_back_a: assert property (wr_ena ##1 !reg_req.wr ##1 reg_req.rd && access_ok // see RL17
        && addr_hit(reg_req.addr, `CDROV_ADDR_ENA) && !reg_req.wr
        |=> reg_rsp.rvalid && reg_rsp.rdata == $past(reg_req.wdata, 3))
        else $error("read back differs from written value");

    cap_override_c: cover property (wr_ena ##1 ena_reg[`CDROV_A_VCO_CAP]);
    refused_c: cover property (reg_req.wr && !access_ok);
    sw_reset_c: cover property (enb_reg[`CDROV_B_RST_OV] && enb_reg[`CDROV_B_RST_VAL]
        ##1 loop_ctl.recovery_reset);
    lock_fd_c: cover property (ena_reg[`CDROV_A_LOCK_FD] && sm_locked_state);
    read_c: cover property (reg_rsp.rvalid);

endmodule // cdrov_regs

// file: testbench/cdrov_regs_bench.sv
// Self-checking bench for the CDR override control registers.
`include "cdrov_defs.svh"

module cdrov_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cdrov_pkg::*;

    logic clock;
    logic rst_n;
    logic acc_en;
    logic ch_sel;
    cdrov_reg_req_t req;
    cdrov_reg_rsp_t rsp;
    cdrov_loop_ctl_t sm_ctl;
    cdrov_loop_ctl_t ov_val;
    logic lk;
    cdrov_loop_ctl_t loop_ctl;
    logic [7:0] m8, m9, ma, old;
    logic [63:0] rnd;
    int failures;
    int cmp_count;

    cdrov_regs u_cdrov_regs (
        .clock(clock),
        .rst_n(rst_n),
        .channel_bus_access_en(acc_en),
        .channel_selected(ch_sel),
        .reg_req(req),
        .reg_rsp(rsp),
        .sm_ctl(sm_ctl),
        .ov_val(ov_val),
        .sm_locked_state(lk),
        .loop_ctl(loop_ctl)
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ------------------------------------------------------------------------
    // Reference model and compare tasks
    // ------------------------------------------------------------------------
    function automatic cdrov_loop_ctl_t exp_ctl(input cdrov_loop_ctl_t s, o, input logic l,
                                                input logic [7:0] a, b);
        cdrov_loop_ctl_t e;
        e = s;
        if (a[7]) e.vco_cap_count = o.vco_cap_count;
        if (a[6]) e.loop_filter_dac = o.loop_filter_dac;
        if (a[5]) e.loopthrough_sel = o.loopthrough_sel;
        if (a[4])
        begin
            e.frequency_detector_enable = o.frequency_detector_enable;
            e.phase_detector_powerdown = o.phase_detector_powerdown;
            e.vco_powerdown = o.vco_powerdown;
            e.quadrature_detector_powerdown = o.quadrature_detector_powerdown;
        end
        else if (a[0] && l) e.frequency_detector_enable = 1'b1;
        if (a[3])
        begin
            e.freq_charge_pump_powerdown = o.freq_charge_pump_powerdown;
            e.phase_charge_pump_powerdown = o.phase_charge_pump_powerdown;
        end
        if (a[2]) e.divider_select = o.divider_select;
        if (a[1]) e.fast_lock_detector_powerdown = o.fast_lock_detector_powerdown;
        if (b[7]) e.single_bit_transition_en = o.single_bit_transition_en;
        if (b[6])
        begin
            e.phase_pump_current = o.phase_pump_current;
            e.freq_pump_current = o.freq_pump_current;
        end
        if (b[5]) e.filter_trip_level = o.filter_trip_level;
        if (b[4]) e.filter_range_enable = o.filter_range_enable;
        if (b[3]) e.recovery_reset = b[2];
        if (b[1]) e.recovery_lock = b[0];
        return e;
    endfunction

    task automatic chk_reg(input string nm, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_ctl();
        cdrov_loop_ctl_t e;
        repeat (2) @(negedge clock);
        e = exp_ctl(sm_ctl, ov_val, lk, m9, ma);
        cmp_count++;
        if (loop_ctl !== e)
        begin
            failures++;
            $display("[ERR] loop_ctl expected %h seen %h", e, loop_ctl);
        end
    endtask

    // ------------------------------------------------------------------------
    // Bus and stimulus tasks
    // ------------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clock);
        req.wr = 1'b0;
        if (acc_en && ch_sel && a == `CDROV_ADDR_RSVD) m8 = d;
        if (acc_en && ch_sel && a == `CDROV_ADDR_ENA) m9 = d;
        if (acc_en && ch_sel && a == `CDROV_ADDR_ENB) ma = d;
        @(negedge clock);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        ok = acc_en && ch_sel;
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        chk_reg("rd_reg", {1'b0, ok, ok ? exp : 8'h00}, {1'b0, rsp.rvalid, rsp.rdata});
        req.rd = 1'b0;
        @(negedge clock);
    endtask

    task automatic rnd_in();
        rnd = {$urandom, $urandom};
        sm_ctl = rnd[$bits(cdrov_loop_ctl_t)-1:0];
        rnd = {$urandom, $urandom};
        ov_val = rnd[$bits(cdrov_loop_ctl_t)-1:0];
        lk = 1'($urandom);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) @(negedge clock);
        chk_reg("reset_outputs", 10'h000, {|loop_ctl, rsp.rvalid, rsp.rdata});
        rst_n = 1'b1;
        m8 = `CDROV_RST_RSVD;
        m9 = `CDROV_RST_ENA;
        ma = `CDROV_RST_ENB;
    endtask

    task automatic summarize();
        $display("Counts: %0d comparisons, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #200000;
        failures++;
        summarize();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        failures = 0;
        cmp_count = 0;
        acc_en = 1'b1;
        ch_sel = 1'b1;
        req = '0;
        void'($urandom(32'hfdf11889));
        rnd_in();
        do_reset();
        chk_ctl();
        rd_reg(`CDROV_ADDR_RSVD, m8);
        rd_reg(`CDROV_ADDR_ENA, m9);
        rd_reg(`CDROV_ADDR_ENB, ma);
        rd_reg(8'h0b, 8'h00);
        $display("Test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            {acc_en, ch_sel} = 2'(i);
            wr_reg(`CDROV_ADDR_ENA, 8'(8'ha5 + i));
            rd_reg(`CDROV_ADDR_ENA, m9);
        end
        $display("Test access refusal done");
        for (int i = 0; i < 16; i++)
        begin
            wr_reg(i < 8 ? `CDROV_ADDR_ENA : `CDROV_ADDR_ENB, 8'h01 << (i % 8));
            rnd_in();
            chk_ctl();
            if (i == 7) wr_reg(`CDROV_ADDR_ENA, 8'h00);
        end
        $display("Test single enables done");
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`CDROV_ADDR_ENA, i[1] ? 8'h11 : 8'h01);
            sm_ctl.frequency_detector_enable = 1'b0;
            ov_val.frequency_detector_enable = 1'b0;
            lk = i[0];
            chk_ctl();
            wr_reg(`CDROV_ADDR_ENB, {4'h0, 1'b1, i[1], 1'b1, i[0]});
            chk_ctl();
        end
        $display("Test lock mode and software reset done");
        for (int i = 0; i < 40; i++)
        begin
            wr_reg(`CDROV_ADDR_ENA, 8'($urandom));
            wr_reg(`CDROV_ADDR_ENB, 8'($urandom));
            rnd_in();
            chk_ctl();
            rd_reg(`CDROV_ADDR_ENB, ma);
        end
        $display("Test random overrides done");
        wr_reg(`CDROV_ADDR_RSVD, 8'h9c);
        wr_reg(8'h0c, 8'hff);
        rd_reg(`CDROV_ADDR_RSVD, m8);
        rd_reg(8'h0c, 8'h00);
        old = m9;
        req.rd = 1'b1;
        req.wr = 1'b1;
        req.addr = `CDROV_ADDR_ENA;
        req.wdata = ~old;
        @(negedge clock);
        chk_reg("same_cycle_read", {2'b01, old}, {1'b0, rsp.rvalid, rsp.rdata});
        req.rd = 1'b0;
        req.wr = 1'b0;
        m9 = ~old;
        @(negedge clock);
        rd_reg(`CDROV_ADDR_ENA, m9);
        $display("Test reserved and unmapped done");
        do_reset();
        rd_reg(`CDROV_ADDR_ENA, m9);
        rd_reg(`CDROV_ADDR_ENB, ma);
        chk_ctl();
        $display("Test second reset done");
        summarize();
    end

endmodule // cdrov_regs_bench
